// ### core/csh_handshake.v
/*
 * Status and completion line handshake of a configuration port.
 * Assumes open-drain lines resolved outside (wired-AND with pull-ups),
 * a loader that reports words and errors on i_clock, and i_nrst as
 * the power-on reset.
 */
// Operation
// - Hold status low through power-on interval
// - Drive status low on configuration error
// - External status low enters error state
// - Ignore status line once in user mode
// - Status rising after reset starts configuration
// - Hold completion low during data transfer
// - Release completion after error-free data
// - Enter user mode after completion seen high
// - Completion low ignored in user mode
// - Request low in user mode resets device
`timescale 1ns/1ps
`default_nettype none
`include "csh_defs.vh"

module csh_handshake #(
    parameter POR_TIME_US = `CSH_POR_TIME_US,
    parameter POR_CYCLES = (POR_TIME_US * `CSH_PS_PER_US + `CSH_CLK_PERIOD_PS - 1) / `CSH_CLK_PERIOD_PS,
    parameter INIT_CYCLES = `CSH_INIT_CYCLES,
    parameter CNT_W = 24
) (
    input wire i_clock,
    input wire i_nrst,
    input wire i_cfg_status_line_n,
    output reg o_cfg_status_line_n,
    output reg o_cfg_status_line_n_oe,
    input wire i_cfg_complete_line,
    output reg o_cfg_complete_line,
    output reg o_cfg_complete_line_oe,
    input wire i_cfg_request_line_n,
    input wire i_word_valid,
    input wire i_load_error,
    input wire i_load_last,
    output reg o_load_enable,
    output reg o_init_active,
    output reg o_user_mode,
    output reg o_io_tristate,
    output reg o_error
);

    localparam integer POR_LAST_I = POR_CYCLES - 1;
    localparam integer INIT_LAST_I = INIT_CYCLES - 1;
    localparam [CNT_W-1:0] POR_LAST = POR_LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] INIT_LAST = INIT_LAST_I[CNT_W-1:0];

    wire status_s;
    wire complete_s;
    wire request_s;

    reg [5:0] state_q;
    reg [5:0] state_d;
    reg [CNT_W-1:0] cnt_q;
    reg [CNT_W-1:0] cnt_d;
    reg data_done_q;
    reg data_done_d;

    csh_sync #(.RESET_VAL(1'b0)) u_sync_status (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_async(i_cfg_status_line_n),
        .o_sync(status_s)
    );
    csh_sync #(.RESET_VAL(1'b0)) u_sync_complete (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_async(i_cfg_complete_line),
        .o_sync(complete_s)
    );
    csh_sync #(.RESET_VAL(1'b0)) u_sync_request (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_async(i_cfg_request_line_n),
        .o_sync(request_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // One-hot test; a single AND term keeps the decode shallow
    function in_state;
        input [5:0] st;
        input [5:0] code;
        begin
            in_state = |(st & code);
        end
    endfunction

    // Counter step shared by the power-on and initialization intervals
    function [CNT_W-1:0] cnt_inc;
        input [CNT_W-1:0] cnt;
        begin
            cnt_inc = cnt + 1'b1;
        end
    endfunction

    // Next-state decode feeding the registered outputs
    wire nxt_por = in_state(state_d, `CSH_ST_POR);
    wire nxt_load = in_state(state_d, `CSH_ST_LOAD);
    wire nxt_init = in_state(state_d, `CSH_ST_INIT);
    wire nxt_user = in_state(state_d, `CSH_ST_USER);
    wire nxt_err = in_state(state_d, `CSH_ST_ERR);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        data_done_d = data_done_q;
        case (state_q)
            `CSH_ST_POR: begin
                // Count the power-on interval, then release status
                if (cnt_q == POR_LAST) begin
                    state_d = `CSH_ST_WAIT;
                    cnt_d = {CNT_W{1'b0}};
                end else begin
                    cnt_d = cnt_inc(cnt_q);
                end
            end
            `CSH_ST_WAIT: begin
                // Forget an earlier image so completion is pulled low again
                data_done_d = 1'b0;
                // Load starts once status reads high and request is high
                if (status_s && request_s) begin
                    state_d = `CSH_ST_LOAD;
                    data_done_d = 1'b0;
                end
            end
            `CSH_ST_LOAD: begin
                if (!request_s) begin
                    state_d = `CSH_ST_WAIT;
                end else if (i_load_error || !status_s) begin
                    // Own error or a low driven from outside
                    state_d = `CSH_ST_ERR;
                end else if (i_word_valid && i_load_last) begin
                    data_done_d = 1'b1;
                end else if (data_done_q && complete_s) begin
                    // Completion seen high after all data
                    state_d = `CSH_ST_INIT;
                    cnt_d = {CNT_W{1'b0}};
                end
            end
            `CSH_ST_INIT: begin
                if (!request_s) begin
                    state_d = `CSH_ST_WAIT;
                end else if (!status_s) begin
                    state_d = `CSH_ST_ERR;
                end else if (cnt_q == INIT_LAST) begin
                    state_d = `CSH_ST_USER;
                end else begin
                    cnt_d = cnt_inc(cnt_q);
                end
            end
            `CSH_ST_USER: begin
                // Status and completion lines are not looked at here
                // Only the request line can discard the configuration
                if (!request_s) begin
                    state_d = `CSH_ST_WAIT;
                end
            end
            `CSH_ST_ERR: begin
                // Hold status low until our own low comes back through the synchroniser;
                // a shorter pulse would echo in as a fresh external error
                if (!status_s) begin
                    state_d = `CSH_ST_WAIT;
                end
            end
            default: begin
                state_d = `CSH_ST_POR;
                cnt_d = {CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= `CSH_ST_POR;
            cnt_q <= {CNT_W{1'b0}};
            data_done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            data_done_q <= data_done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered pin and status outputs

    // Lines only ever pull low; data bit is a constant zero
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cfg_status_line_n <= 1'b0;
            o_cfg_status_line_n_oe <= 1'b1;
            o_cfg_complete_line <= 1'b0;
            o_cfg_complete_line_oe <= 1'b1;
            o_load_enable <= 1'b0;
            o_init_active <= 1'b0;
            o_user_mode <= 1'b0;
            o_io_tristate <= 1'b1;
            o_error <= 1'b0;
        end else begin
            o_cfg_status_line_n <= 1'b0;
            o_cfg_status_line_n_oe <= nxt_por | nxt_err;
            o_cfg_complete_line <= 1'b0;
            // Low until all data is in, released from then until the next return to WAIT
            o_cfg_complete_line_oe <= ~data_done_d & ~nxt_init & ~nxt_user;
            o_load_enable <= nxt_load & ~data_done_d;
            o_init_active <= nxt_init;
            o_user_mode <= nxt_user;
            o_io_tristate <= ~nxt_user;
            o_error <= nxt_err;
        end
    end

endmodule

`default_nettype wire

// ### core/csh_defs.vh
/*
 * Shared constants of the configuration status handshake block.
 * Assumes inclusion by bare name from files under core/.
 */
`ifndef CSH_DEFS_VH
`define CSH_DEFS_VH

// Clock period in picoseconds (250 MHz)
`define CSH_CLK_PERIOD_PS 4000
// Picoseconds in one microsecond
`define CSH_PS_PER_US 1000000
// Default power-on reset interval in microseconds
`define CSH_POR_TIME_US 100
// Default initialization interval in clock cycles
`define CSH_INIT_CYCLES 64

// One-hot state codes
`define CSH_ST_POR 6'h01
`define CSH_ST_WAIT 6'h02
`define CSH_ST_LOAD 6'h04
`define CSH_ST_INIT 6'h08
`define CSH_ST_USER 6'h10
`define CSH_ST_ERR 6'h20

`endif

// ### core/csh_sync.v
/*
 * Two-flop synchroniser for a level from a pin.
 * Assumes the input is asynchronous to i_clock.
 */
`timescale 1ns/1ps
`default_nettype none

module csh_sync #(
    parameter RESET_VAL = 1'b1
) (
    input wire i_clock,
    input wire i_nrst,
    input wire i_async,
    output wire o_sync
);

    reg meta_q;
    reg sync_q;

    // First flop feeds only the second flop
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

`default_nettype wire

// ### test/csh_handshake_properties.sv
/* Checker of the status and completion handshake ports.
   Assumes it is bound onto csh_handshake, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module csh_props (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_cfg_status_line_n,
    input wire logic o_cfg_status_line_n,
    input wire logic o_cfg_status_line_n_oe,
    input wire logic i_cfg_complete_line,
    input wire logic o_cfg_complete_line,
    input wire logic o_cfg_complete_line_oe,
    input wire logic i_cfg_request_line_n,
    input wire logic i_word_valid,
    input wire logic i_load_last,
    input wire logic o_load_enable,
    input wire logic o_init_active,
    input wire logic o_user_mode,
    input wire logic o_io_tristate,
    input wire logic o_error
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////
    property p_por; $rose(i_nrst) |-> o_cfg_status_line_n_oe [*7]; endproperty
    a_por: assert property (p_por) else $error("status released early");
    property p_drv; !o_cfg_status_line_n && !o_cfg_complete_line; endproperty
    a_drv: assert property (p_drv) else $error("line driven high");
    property p_err; o_error |-> o_cfg_status_line_n_oe; endproperty
    a_err: assert property (p_err) else $error("error without status low");
    // Sync latency plus one decision edge
    property p_ext; o_init_active && !i_cfg_status_line_n |-> ##[1:4] o_error; endproperty
    a_ext: assert property (p_ext) else $error("external low missed");
    // Request reaches the state two edges late
    property p_usr; o_user_mode && i_cfg_request_line_n && $past(i_cfg_request_line_n, 2) |=> o_user_mode; endproperty
    a_usr: assert property (p_usr) else $error("user mode lost");
    property p_load; o_load_enable |-> o_cfg_complete_line_oe; endproperty
    a_load: assert property (p_load) else $error("completion free in load");
    property p_rel; $fell(o_cfg_complete_line_oe) |-> $past(i_word_valid && i_load_last); endproperty
    a_rel: assert property (p_rel) else $error("completion freed early");
    property p_init; $rose(o_init_active) |-> $past(i_cfg_complete_line, 3); endproperty
    a_init: assert property (p_init) else $error("init without completion");
    property p_req; o_user_mode && !i_cfg_request_line_n |-> ##[1:4] (o_io_tristate && !o_user_mode); endproperty
    a_req: assert property (p_req) else $error("request low ignored");
endmodule
bind csh_handshake csh_props u_chk (.*);
`default_nettype wire

// ### test/csh_cfg_mem.sv
/* Configuration memory model feeding words to the loader port.
   Assumes the bench resolves the status wire. */
`timescale 1ns/1ps
`default_nettype none
module csh_cfg_mem #(parameter int NW = 4) (
    input wire logic i_clock,
    input wire logic i_load_enable,
    input wire logic i_status_line_n,
    output logic o_word_valid = 1'b0,
    output logic o_load_last = 1'b0
);
    int cnt = 0;
    always @(negedge i_clock) begin
        o_word_valid <= 1'b0;
        o_load_last <= 1'b0;
        if (!i_status_line_n || !i_load_enable) begin
            cnt <= 0; // Restart the whole image
        end else if (cnt < NW) begin
            o_word_valid <= 1'b1;
            o_load_last <= (cnt == NW - 1);
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ### test/csh_handshake_tb.sv
/* Testbench of the status handshake.
   Assumes wired-AND lines with pull-ups, resolved here. */
`timescale 1ns/1ps
`default_nettype none
module csh_handshake_tb;
    logic clk = 0, nrst = 0, req = 1, ext_st = 0, ext_cp = 0, ld_err = 0;
    wire st_oe, cp_oe, st_do, cp_do, wv, last, en, ini, usr, tri_q, err;
    wire st_w = !ext_st && (!st_oe || st_do);
    wire cp_w = !ext_cp && (!cp_oe || cp_do);
    int num_errors = 0, checks_done = 0;
    initial forever #2 clk = ~clk;
    csh_handshake #(.POR_CYCLES(8), .INIT_CYCLES(16)) dut_u (.i_clock(clk), .i_nrst(nrst),
        .i_cfg_status_line_n(st_w), .o_cfg_status_line_n(st_do), .o_cfg_status_line_n_oe(st_oe),
        .i_cfg_complete_line(cp_w), .o_cfg_complete_line(cp_do), .o_cfg_complete_line_oe(cp_oe),
        .i_cfg_request_line_n(req), .i_word_valid(wv), .i_load_error(ld_err), .i_load_last(last),
        .o_load_enable(en), .o_init_active(ini), .o_user_mode(usr), .o_io_tristate(tri_q), .o_error(err));
    csh_cfg_mem mem_u (.i_clock(clk), .i_load_enable(en), .i_status_line_n(st_w),
        .o_word_valid(wv), .o_load_last(last));
    ////////////////////////////////////////
    task chk(input logic a, input logic e);
        checks_done++;
        if (a !== e) begin
            num_errors++;
            $display("FAIL t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task give_verdict;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Bounded wait, since a stuck state would hang here
    task wait_user;
        for (int n = 0; n < 80 && usr !== 1'b1; n++) @(negedge clk);
        chk(usr, 1'b1);
        chk(cp_w, 1'b1);
        chk(tri_q, 1'b0);
    endtask
    task t_boot;
        nrst = 1;
        repeat (4) @(negedge clk);
        chk(st_w, 1'b0);
        chk(cp_w, 1'b0);
        wait_user();
    endtask
    task t_ignore;
        ext_st = 1;
        ext_cp = 1;
        repeat (6) @(negedge clk);
        ext_st = 0;
        ext_cp = 0;
        chk(usr, 1'b1);
    endtask
    task t_req;
        req = 0;
        repeat (6) @(negedge clk);
        chk(usr, 1'b0);
        chk(tri_q, 1'b1);
        chk(cp_w, 1'b0);
        req = 1;
    endtask
    task t_err;
        t_req();
        for (int n = 0; n < 20 && en !== 1'b1; n++) @(negedge clk);
        ld_err = 1;
        @(negedge clk);
        ld_err = 0;
        for (int n = 0; n < 8 && err !== 1'b1; n++) @(negedge clk);
        chk(err, 1'b1);
        chk(st_w, 1'b0);
        wait_user();
    endtask
    task t_ext;
        t_req();
        for (int n = 0; n < 40 && ini !== 1'b1; n++) @(negedge clk);
        ext_st = 1;
        for (int n = 0; n < 8 && err !== 1'b1; n++) @(negedge clk);
        ext_st = 0;
        chk(err, 1'b1);
        wait_user();
    endtask
    initial begin
        repeat (10) @(negedge clk);
        t_boot();
        t_ignore();
        t_req();
        wait_user();
        t_err();
        t_ext();
        give_verdict();
    end
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
